// File: design/scr_cfg.svh
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// Direct addresses of the implemented special registers.
`define SCR_ADDR_PORT0_LATCH 8'h80
`define SCR_ADDR_STACK_TOP 8'h81
`define SCR_ADDR_DPTR_LOW 8'h82
`define SCR_ADDR_DPTR_HIGH 8'h83
`define SCR_ADDR_PULLUP_CTRL 8'h8F
`define SCR_ADDR_PORT1_PINS 8'h90

// Field positions.
`define SCR_SPACE_BIT 7
`define SCR_PULLUP_EN_BIT 0
`define SCR_BITADDR_LSB_W 3

// Reset values.
`define SCR_RST_PORT0_LATCH 8'hFF
`define SCR_RST_STACK_TOP 8'h07
`define SCR_RST_DPTR_LOW 8'h00
`define SCR_RST_DPTR_HIGH 8'h00
`define SCR_RST_PULLUP_EN 1'h0

// Read value of anything that is not implemented.
`define SCR_UNIMPL_BYTE 8'hFF
`define SCR_PULLUP_UNUSED_BITS 7'h7F

// Timing counts in clocks and machine cycles.
`define SCR_MC_CLOCKS 4
`define SCR_MC_LAST 2'h3
`define SCR_TIMER_FAST_CLOCKS 4'h4
`define SCR_TIMER_SLOW_CLOCKS 4'hC
`define SCR_XMOVE_MIN_MC 2
`define SCR_XMOVE_MAX_MC 9

`endif

// File: design/scr_pkg.sv
package scr_pkg;

  // Phases of one external data move.
  typedef enum logic [1:0] {
    XM_IDLE = 2'b00,
    XM_ADDR = 2'b01,
    XM_DATA = 2'b10
  } scr_xmove_state_e;

  typedef logic [7:0] scr_byte_t;

endpackage

// File: design/scr_ram_if.sv
`timescale 1ns/100ps
// Scratchpad access port between the decode logic and the memory.
interface scr_ram_if;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport core (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// File: design/scr_scratch.sv
`timescale 1ns/100ps
module scr_scratch #(
  parameter int DEPTH = 256
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Access port.
  scr_ram_if.mem ram
);

  logic [7:0] mem_q [DEPTH];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Content is left unreset, as real scratchpad cells are.
  always_ff @(posedge clk_in) begin
    if (ram.we) begin
      mem_q[ram.addr] <= ram.wdata;
    end
  end

  // Reads are combinational so a byte written can be read back next cycle.
  assign ram.rdata = mem_q[ram.addr];

  a_ram_write_lands: assert property (ram.we |=> mem_q[$past(ram.addr)] == $past(ram.wdata))
    else $error("Scratchpad write did not land.");

endmodule

// File: design/scr_xmove.sv
`timescale 1ns/100ps
`include "scr_cfg.svh"
module scr_xmove (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Request side.
  input wire logic mc_end_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [2:0] stretch_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] pin_in,
  // Status and read data.
  output logic busy_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  // Bus side.
  output logic bus_own_out,
  output logic bus_drive_out,
  output logic [7:0] bus_data_out,
  output logic [7:0] addr_hi_out,
  output logic ale_out,
  output logic rd_n_out,
  output logic wr_n_out
);

  scr_pkg::scr_xmove_state_e state_reg;
  logic [3:0] mc_left_reg;
  logic write_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic take;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // A move is only started on a machine-cycle boundary.
  assign take = start_in && mc_end_in && (state_reg == scr_pkg::XM_IDLE);

  // Sequencer: one address cycle, then stretch+1 data cycles.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= scr_pkg::XM_IDLE;
      mc_left_reg <= 4'h0;
    end else if (mc_end_in) begin
      case (state_reg)
        scr_pkg::XM_IDLE: begin
          if (start_in) begin
            state_reg <= scr_pkg::XM_ADDR;
            mc_left_reg <= {1'b0, stretch_in} + 4'h1;
          end
        end
        scr_pkg::XM_ADDR: begin
          state_reg <= scr_pkg::XM_DATA;
        end
        scr_pkg::XM_DATA: begin
          if (mc_left_reg == 4'h1) begin
            state_reg <= scr_pkg::XM_IDLE;
          end
          mc_left_reg <= mc_left_reg - 4'h1;
        end
        default: begin
          state_reg <= scr_pkg::XM_IDLE;
        end
      endcase
    end
  end

  // Operands are frozen for the whole move.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      write_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end else if (take) begin
      write_reg <= write_in;
      addr_reg <= addr_in;
      wdata_reg <= wdata_in;
    end
  end

  // Read data is sampled at the close of the last data cycle.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      done_out <= mc_end_in && (state_reg == scr_pkg::XM_DATA) && (mc_left_reg == 4'h1);
      if (mc_end_in && (state_reg == scr_pkg::XM_DATA) && (mc_left_reg == 4'h1) && !write_reg) begin
        rdata_out <= pin_in;
      end
    end
  end

  // Bus view decoded from the sequencer state.
  always_comb begin
    busy_out = (state_reg != scr_pkg::XM_IDLE);
    bus_own_out = busy_out;
    ale_out = (state_reg == scr_pkg::XM_ADDR);
    bus_drive_out = ale_out || ((state_reg == scr_pkg::XM_DATA) && write_reg);
    bus_data_out = ale_out ? addr_reg[7:0] : wdata_reg;
    addr_hi_out = addr_reg[15:8];
    rd_n_out = !((state_reg == scr_pkg::XM_DATA) && !write_reg);
    wr_n_out = !((state_reg == scr_pkg::XM_DATA) && write_reg);
  end

  a_xmove_length: assert property (take |-> ##[9:37] done_out)
    else $error("External move did not finish within two to nine machine cycles.");

endmodule

// File: design/scr_core.sv
// Function
// - Special registers sit at 80h-FFh and answer only direct accesses.
// - Bit set, clear and read only on registers at addresses ending 0 or 8.
// - Unmapped addresses and unimplemented bits read as one.
// - The 256-byte scratchpad takes direct and indirect accesses, indirect reaching 80h-FFh.
// - A machine cycle lasts four clocks.
// - An external data move lasts two to nine machine cycles, programmable.
// - Timer ticks come every four or every twelve clocks, selectable.
// - External moves to 0000h-FFFFh go out on ports zero and two.
// - Port zero drives both levels as a bus, otherwise is open drain.
// - Port two drives the upper address byte while port zero is a bus.
// - Port one is input only and alone feeds the converter inputs.
// - Port zero is open drain after reset; a control bit enables pull-ups.
// - The port zero latch sits at 80h, bit n for pin n.
// - The stack top pointer at 81h holds an eight-bit scratchpad address.
// - The register at 82h holds the data pointer low byte.
// - The pull-up enable is bit 0 of the control register at 8Fh.
// - The register at 83h holds the data pointer high byte.
`timescale 1ns/100ps
`include "scr_cfg.svh"
module scr_core (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Register access from the instruction engine.
  input wire logic acc_valid_in,
  input wire logic acc_write_in,
  input wire logic acc_indirect_in,
  input wire logic acc_bit_in,
  input wire logic [7:0] acc_addr_in,
  input wire logic [2:0] acc_bitsel_in,
  input wire logic [7:0] acc_wdata_in,
  input wire logic acc_bitval_in,
  output logic acc_done_out,
  output logic [7:0] acc_rdata_out,
  output logic acc_bit_refused_out,
  // Machine cycle and timer prescale.
  output logic mc_end_out,
  input wire logic timer_slow_in,
  output logic timer_tick_out,
  // External data move requests.
  input wire logic xmove_req_in,
  input wire logic xmove_write_in,
  input wire logic [2:0] xmove_stretch_in,
  input wire logic [7:0] xmove_wdata_in,
  output logic xmove_busy_out,
  output logic xmove_done_out,
  output logic [7:0] xmove_rdata_out,
  // Port zero pins.
  input wire logic [7:0] port0_pin_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_oe_n_out,
  output logic port_zero_pullup_enable_out,
  // Port two pins.
  output logic [7:0] port2_pin_out,
  output logic [7:0] port2_oe_n_out,
  // Bus strobes.
  output logic ale_out,
  output logic rd_n_out,
  output logic wr_n_out,
  // Port one pins and converter feed.
  input wire logic [7:0] port1_pin_in,
  output logic [7:0] adc_pins_out
);

  logic [1:0] phase_reg;
  logic [3:0] tick_cnt_reg;
  logic [7:0] port_zero_latch_reg;
  logic [7:0] stack_top_pointer_reg;
  logic [7:0] data_pointer_low_byte_reg;
  logic [7:0] data_pointer_high_byte_reg;
  logic port_zero_pullup_enable_reg;
  logic [7:0] port0_meta_reg;
  logic [7:0] port0_sync_reg;
  logic [7:0] port1_meta_reg;
  logic [7:0] port1_sync_reg;
  logic port0_bus_reg;
  logic mc_end;
  logic take;
  logic is_space;
  logic bit_ok;
  logic bit_refused;
  logic commit;
  logic [7:0] space_byte;
  logic [7:0] cur_byte;
  logic [7:0] wr_byte;
  logic [7:0] rd_result;
  logic xm_busy;
  logic xm_done;
  logic [7:0] xm_rdata;
  logic xm_own;
  logic xm_drive;
  logic [7:0] xm_data;
  logic [7:0] xm_addr_hi;
  logic xm_ale;
  logic xm_rd_n;
  logic xm_wr_n;

  scr_ram_if ram_bus ();

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Four-clock machine cycle; every register access closes on its last clock.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign mc_end = (phase_reg == `SCR_MC_LAST);

  // Timer prescale: the selection is compared every clock, so a change takes effect on the count in progress.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_reg <= 4'h0;
      timer_tick_out <= 1'b0;
    end else begin
      if (tick_cnt_reg >= (timer_slow_in ? `SCR_TIMER_SLOW_CLOCKS : `SCR_TIMER_FAST_CLOCKS)
          - 4'h1) begin
        tick_cnt_reg <= 4'h0;
        timer_tick_out <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 4'h1;
        timer_tick_out <= 1'b0;
      end
    end
  end

  // Pins come from outside the clock domain, so both ports are synchronised.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port0_meta_reg <= 8'h00;
      port0_sync_reg <= 8'h00;
      port1_meta_reg <= 8'h00;
      port1_sync_reg <= 8'h00;
    end else begin
      port0_meta_reg <= port0_pin_in;
      port0_sync_reg <= port0_meta_reg;
      port1_meta_reg <= port1_pin_in;
      port1_sync_reg <= port1_meta_reg;
    end
  end

  assign adc_pins_out = port1_sync_reg;

  // Address decode; indirect accesses never reach the register space.
  always_comb begin
    take = acc_valid_in && mc_end;
    is_space = !acc_indirect_in && acc_addr_in[`SCR_SPACE_BIT];
    bit_ok = (acc_addr_in[`SCR_BITADDR_LSB_W-1:0] == 3'h0);
    bit_refused = acc_bit_in && !(is_space && bit_ok);
    commit = take && acc_write_in && !bit_refused;
  end

  // Register read mux; holes and spare bits read as ones.
  always_comb begin
    case (acc_addr_in)
      `SCR_ADDR_PORT0_LATCH: space_byte = port_zero_latch_reg;
      `SCR_ADDR_STACK_TOP: space_byte = stack_top_pointer_reg;
      `SCR_ADDR_DPTR_LOW: space_byte = data_pointer_low_byte_reg;
      `SCR_ADDR_DPTR_HIGH: space_byte = data_pointer_high_byte_reg;
      `SCR_ADDR_PULLUP_CTRL: space_byte = {`SCR_PULLUP_UNUSED_BITS,
                                           port_zero_pullup_enable_reg};
      `SCR_ADDR_PORT1_PINS: space_byte = port1_sync_reg;
      default: space_byte = `SCR_UNIMPL_BYTE;
    endcase
    cur_byte = is_space ? space_byte : ram_bus.rdata;
    wr_byte = cur_byte;
    if (acc_bit_in) begin
      wr_byte[acc_bitsel_in] = acc_bitval_in;
    end else begin
      wr_byte = acc_wdata_in;
    end
    rd_result = acc_bit_in ? {7'h00, cur_byte[acc_bitsel_in]} : cur_byte;
  end

  // Scratchpad port; it also catches indirect accesses to 80h-FFh.
  assign ram_bus.we = commit && !is_space;
  assign ram_bus.addr = acc_addr_in;
  assign ram_bus.wdata = wr_byte;

  scr_scratch #(
    .DEPTH(256)
  ) u_scratch (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ram(ram_bus.mem)
  );

  // Access answer is a one-cycle pulse after the closing edge.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_done_out <= 1'b0;
      acc_rdata_out <= 8'h00;
      acc_bit_refused_out <= 1'b0;
      mc_end_out <= 1'b0;
    end else begin
      acc_done_out <= take;
      acc_bit_refused_out <= take && bit_refused;
      mc_end_out <= mc_end;
      if (take && !acc_write_in && !bit_refused) begin
        acc_rdata_out <= rd_result;
      end
    end
  end

  // Port zero latch, reset to all ones so every pin is released.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_zero_latch_reg <= `SCR_RST_PORT0_LATCH;
    end else if (commit && is_space && acc_addr_in == `SCR_ADDR_PORT0_LATCH) begin
      port_zero_latch_reg <= wr_byte;
    end
  end

  // Stack top pointer.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stack_top_pointer_reg <= `SCR_RST_STACK_TOP;
    end else if (commit && is_space && acc_addr_in == `SCR_ADDR_STACK_TOP) begin
      stack_top_pointer_reg <= wr_byte;
    end
  end

  // Data pointer, both halves; together they address external moves.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_pointer_low_byte_reg <= `SCR_RST_DPTR_LOW;
      data_pointer_high_byte_reg <= `SCR_RST_DPTR_HIGH;
    end else begin
      if (commit && is_space && acc_addr_in == `SCR_ADDR_DPTR_LOW) begin
        data_pointer_low_byte_reg <= wr_byte;
      end
      if (commit && is_space && acc_addr_in == `SCR_ADDR_DPTR_HIGH) begin
        data_pointer_high_byte_reg <= wr_byte;
      end
    end
  end

  // Pull-up control; only bit 0 is kept, so pull-ups are off after reset.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_zero_pullup_enable_reg <= `SCR_RST_PULLUP_EN;
    end else if (commit && is_space && acc_addr_in == `SCR_ADDR_PULLUP_CTRL) begin
      port_zero_pullup_enable_reg <= wr_byte[`SCR_PULLUP_EN_BIT];
    end
  end

  // External moves always use the expanded bus; there is no internal window.
  scr_xmove u_xmove (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .mc_end_in(mc_end),
    .start_in(xmove_req_in),
    .write_in(xmove_write_in),
    .stretch_in(xmove_stretch_in),
    .addr_in({data_pointer_high_byte_reg, data_pointer_low_byte_reg}),
    .wdata_in(xmove_wdata_in),
    .pin_in(port0_sync_reg),
    .busy_out(xm_busy),
    .done_out(xm_done),
    .rdata_out(xm_rdata),
    .bus_own_out(xm_own),
    .bus_drive_out(xm_drive),
    .bus_data_out(xm_data),
    .addr_hi_out(xm_addr_hi),
    .ale_out(xm_ale),
    .rd_n_out(xm_rd_n),
    .wr_n_out(xm_wr_n)
  );

  // Move status re-registered so every output leaves from a flop.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      xmove_busy_out <= 1'b0;
      xmove_done_out <= 1'b0;
      xmove_rdata_out <= 8'h00;
    end else begin
      xmove_busy_out <= xm_busy;
      xmove_done_out <= xm_done;
      xmove_rdata_out <= xm_rdata;
    end
  end

  // Pin drivers. As a bus both ports push both levels; otherwise port zero
  // only ever pulls low, which is why a released latch bit floats.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port0_bus_reg <= 1'b0;
      port0_pin_out <= 8'h00;
      port0_oe_n_out <= 8'hFF;
      port2_pin_out <= 8'h00;
      port2_oe_n_out <= 8'hFF;
      ale_out <= 1'b0;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
    end else begin
      port0_bus_reg <= xm_own;
      ale_out <= xm_ale;
      rd_n_out <= xm_rd_n;
      wr_n_out <= xm_wr_n;
      if (xm_own) begin
        port0_pin_out <= xm_data;
        port0_oe_n_out <= xm_drive ? 8'h00 : 8'hFF;
        port2_pin_out <= xm_addr_hi;
        port2_oe_n_out <= 8'h00;
      end else begin
        port0_pin_out <= 8'h00;
        port0_oe_n_out <= port_zero_latch_reg;
        port2_pin_out <= 8'h00;
        port2_oe_n_out <= 8'hFF;
      end
    end
  end

  assign port_zero_pullup_enable_out = port_zero_pullup_enable_reg;

  // A fast selection seen on the third clock after a tick makes the next clock tick.
  sequence s_fast_gap;
    timer_tick_out ##1 !timer_tick_out [*2] ##1 (!timer_tick_out && !timer_slow_in);
  endsequence

  a_mc_four_clocks: assert property (mc_end |-> ##4 mc_end)
    else $error("Machine cycle is not four clocks.");
  a_timer_fast_rate: assert property (s_fast_gap |=> timer_tick_out)
    else $error("Fast timer tick spacing wrong.");
  a_write_at_mc_end: assert property (acc_done_out |-> $past(phase_reg) == `SCR_MC_LAST)
    else $error("Access answered off the machine-cycle boundary.");
  a_unmapped_reads_one: assert property (take && !acc_write_in && !acc_bit_in && is_space
      && acc_addr_in == 8'hA0 |=> acc_rdata_out == 8'hFF)
    else $error("Unmapped register did not read as ones.");
  a_bit_refused: assert property (take && acc_bit_in && is_space
      && acc_addr_in[2:0] != 3'h0 |=> acc_bit_refused_out && $stable(port_zero_latch_reg))
    else $error("Bit access to non-bit register was not refused.");
  a_stack_write: assert property (take && acc_write_in && !acc_bit_in && is_space
      && acc_addr_in == 8'h81 |=> stack_top_pointer_reg == $past(acc_wdata_in))
    else $error("Stack top pointer write lost.");
  a_indirect_skips: assert property (take && acc_write_in && acc_indirect_in
      |=> $stable(port_zero_latch_reg) && $stable(stack_top_pointer_reg))
    else $error("Indirect access reached the register space.");
  a_pullup_enable: assert property (take && acc_write_in && !acc_bit_in && is_space
      && acc_addr_in == 8'h8F |=> port_zero_pullup_enable_out == $past(acc_wdata_in[0]))
    else $error("Pull-up enable did not follow bit 0.");
  a_open_drain: assert property (!port0_bus_reg |-> port0_pin_out == 8'h00)
    else $error("Port zero drove high outside bus use.");
  a_port2_addr: assert property (port0_bus_reg |-> port2_oe_n_out == 8'h00)
    else $error("Port two not driving address during bus use.");

endmodule

// File: tb/scr_core_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s expected %0h seen %0h", nm, (e), (g)); end end
module scr_core_tb_top;
  typedef struct {
    logic w;
    logic ind;
    logic bt;
    logic [7:0] addr;
    logic [2:0] sel;
    logic [7:0] wd;
    logic bv;
    logic [7:0] exp_rd;
    logic exp_ref;
  } scr_row_s;

  // Stimulus, design outputs and the port zero wire.
  logic clk_in, rst_in, acc_valid_in, acc_write_in, acc_indirect_in, acc_bit_in, acc_bitval_in;
  logic [7:0] acc_addr_in, acc_wdata_in, xmove_wdata_in, port1_pin_in, ext_p0;
  logic [2:0] acc_bitsel_in, xmove_stretch_in;
  logic timer_slow_in, xmove_req_in, xmove_write_in;
  logic acc_done_out, acc_bit_refused_out, mc_end_out, timer_tick_out, xmove_busy_out;
  logic xmove_done_out, port_zero_pullup_enable_out, ale_out, rd_n_out, wr_n_out;
  logic [7:0] acc_rdata_out, xmove_rdata_out, port0_pin_out, port0_oe_n_out;
  logic [7:0] port2_pin_out, port2_oe_n_out, adc_pins_out, rd;
  wire [7:0] port0_pin_in;
  int mismatches = 0;
  int compares = 0;
  int g;
  logic rf;

  // The outside device drives only the bits that port zero leaves floating.
  assign port0_pin_in = (~port0_oe_n_out & port0_pin_out) | (port0_oe_n_out & ext_p0);

  scr_core u_scr_core (.clk_in(clk_in), .rst_in(rst_in), .acc_valid_in(acc_valid_in),
    .acc_write_in(acc_write_in), .acc_indirect_in(acc_indirect_in), .acc_bit_in(acc_bit_in),
    .acc_addr_in(acc_addr_in), .acc_bitsel_in(acc_bitsel_in), .acc_wdata_in(acc_wdata_in),
    .acc_bitval_in(acc_bitval_in), .acc_done_out(acc_done_out), .acc_rdata_out(acc_rdata_out),
    .acc_bit_refused_out(acc_bit_refused_out), .mc_end_out(mc_end_out),
    .timer_slow_in(timer_slow_in), .timer_tick_out(timer_tick_out),
    .xmove_req_in(xmove_req_in), .xmove_write_in(xmove_write_in),
    .xmove_stretch_in(xmove_stretch_in), .xmove_wdata_in(xmove_wdata_in),
    .xmove_busy_out(xmove_busy_out), .xmove_done_out(xmove_done_out),
    .xmove_rdata_out(xmove_rdata_out), .port0_pin_in(port0_pin_in),
    .port0_pin_out(port0_pin_out), .port0_oe_n_out(port0_oe_n_out),
    .port_zero_pullup_enable_out(port_zero_pullup_enable_out), .port2_pin_out(port2_pin_out),
    .port2_oe_n_out(port2_oe_n_out), .ale_out(ale_out), .rd_n_out(rd_n_out),
    .wr_n_out(wr_n_out), .port1_pin_in(port1_pin_in), .adc_pins_out(adc_pins_out));

  // A 40 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A wait that ran out of its bound is a mismatch and ends the run.
  task automatic stall();
    mismatches++;
    $display("[FAIL] wait bound ran out");
    final_report();
  endtask

  // One register access; valid is held until done, since the take edge is unknown.
  task automatic acc(input scr_row_s r, output logic [7:0] d, output logic f);
    int n;
    @(posedge clk_in);
    acc_valid_in <= 1'b1;
    acc_write_in <= r.w;
    acc_indirect_in <= r.ind;
    acc_bit_in <= r.bt;
    acc_addr_in <= r.addr;
    acc_bitsel_in <= r.sel;
    acc_wdata_in <= r.wd;
    acc_bitval_in <= r.bv;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (acc_done_out !== 1'b1 && n < 20);
    if (acc_done_out !== 1'b1) stall();
    d = acc_rdata_out;
    f = acc_bit_refused_out;
    @(posedge clk_in);
    acc_valid_in <= 1'b0;
  endtask

  // Resets the block and reads back every register's reset value.
  task automatic reset_check();
    logic [7:0] ra [0:5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h8F, 8'h84};
    logic [7:0] rv [0:5] = '{8'hFF, 8'h07, 8'h00, 8'h00, 8'hFE, 8'hFF};
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("p0_oe_n", 8'hFF, port0_oe_n_out)
    `CHK("pullup", 1'b0, port_zero_pullup_enable_out)
    `CHK("strobes", 3'b011, {ale_out, rd_n_out, wr_n_out})
    @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      acc('{1'b0, 1'b0, 1'b0, ra[i], 3'h0, 8'h00, 1'b0, 8'h00, 1'b0}, rd, rf);
      `CHK("reset value", rv[i], rd)
    end
    $display("Test reset done");
  endtask

  // One external move from the data pointer 12A5; checks length, strobes and pins.
  task automatic xm(input logic w, input logic [2:0] s, input logic [7:0] wd);
    int n, bad, ale_n, strb_n;
    @(posedge clk_in);
    xmove_req_in <= 1'b1;
    xmove_write_in <= w;
    xmove_stretch_in <= s;
    xmove_wdata_in <= wd;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (xmove_busy_out !== 1'b1 && n < 20);
    if (xmove_busy_out !== 1'b1) stall();
    bad = 0;
    ale_n = 0;
    strb_n = 0;
    for (n = 1; n < 60; n++) begin
      if (ale_out === 1'b1) begin
        ale_n++;
        if ({port0_pin_out, port2_pin_out, port0_oe_n_out, port2_oe_n_out} !==
            {8'hA5, 8'h12, 16'h0000}) bad++;
      end
      if ((w ? rd_n_out : wr_n_out) !== 1'b1) bad++;
      if ((w ? wr_n_out : rd_n_out) === 1'b0) begin
        strb_n++;
        if (w && {port0_pin_out, port0_oe_n_out} !== {wd, 8'h00}) bad++;
        if (!w && port0_oe_n_out !== 8'hFF) bad++;
      end
      if (xmove_done_out === 1'b1) break;
      @(posedge clk_in);
      xmove_req_in <= 1'b0;
      @(negedge clk_in);
    end
    `CHK("move length", 4 * (s + 2) + 1, n)
    `CHK("address phase", 4, ale_n)
    `CHK("strobe cycles", 4 * (s + 1), strb_n)
    `CHK("bus pins", 0, bad)
    if (!w) `CHK("move read", ext_p0, xmove_rdata_out)
    $display("Test move done");
  endtask

  // Waits for one pulse of the chosen output, then counts the gap to the next.
  task automatic gap(input logic tk, output int c);
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while ((tk ? timer_tick_out : mc_end_out) !== 1'b1 && n < 30);
    c = 0;
    do begin
      @(negedge clk_in);
      c++;
    end while ((tk ? timer_tick_out : mc_end_out) !== 1'b1 && c < 30);
  endtask

  // Ordinary accesses: a read checks its data, every access its refusal flag.
  scr_row_s rows [0:24] = '{
    '{1, 0, 0, 8'h81, 0, 8'h5A, 0, 8'h00, 0}, '{0, 0, 0, 8'h81, 0, 0, 0, 8'h5A, 0},
    '{1, 0, 0, 8'h82, 0, 8'hA5, 0, 8'h00, 0}, '{0, 0, 0, 8'h82, 0, 0, 0, 8'hA5, 0},
    '{1, 0, 0, 8'h83, 0, 8'h12, 0, 8'h00, 0}, '{0, 0, 0, 8'h83, 0, 0, 0, 8'h12, 0},
    '{1, 0, 0, 8'h80, 0, 8'h3C, 0, 8'h00, 0}, '{0, 0, 0, 8'h80, 0, 0, 0, 8'h3C, 0},
    '{1, 1, 0, 8'h85, 0, 8'h77, 0, 8'h00, 0}, '{0, 1, 0, 8'h85, 0, 0, 0, 8'h77, 0},
    '{0, 0, 0, 8'h85, 0, 0, 0, 8'hFF, 0},
    '{1, 0, 0, 8'h8F, 0, 8'hFF, 0, 8'h00, 0}, '{0, 0, 0, 8'h8F, 0, 0, 0, 8'hFF, 0},
    '{1, 0, 1, 8'h80, 0, 0, 1, 8'h00, 0}, '{0, 0, 0, 8'h80, 0, 0, 0, 8'h3D, 0},
    '{0, 0, 1, 8'h80, 2, 0, 0, 8'h01, 0}, '{0, 0, 1, 8'h80, 1, 0, 0, 8'h00, 0},
    '{1, 0, 1, 8'h81, 0, 0, 0, 8'h00, 1}, '{0, 0, 0, 8'h81, 0, 0, 0, 8'h5A, 0},
    '{1, 1, 1, 8'h80, 0, 0, 0, 8'h00, 1}, '{1, 0, 1, 8'h40, 0, 0, 1, 8'h00, 1},
    '{1, 0, 0, 8'h40, 0, 8'h99, 0, 8'h00, 0}, '{0, 1, 0, 8'h40, 0, 0, 0, 8'h99, 0},
    '{0, 0, 0, 8'hA0, 0, 0, 0, 8'hFF, 0},
    '{0, 0, 0, 8'h90, 0, 0, 0, 8'h5C, 0}};

  // Main sequence.
  initial begin
    {rst_in, acc_valid_in, acc_write_in, acc_indirect_in, acc_bit_in, acc_bitval_in} = 6'h20;
    {acc_addr_in, acc_wdata_in, acc_bitsel_in, xmove_stretch_in, xmove_wdata_in} = 30'h0;
    {timer_slow_in, xmove_req_in, xmove_write_in} = 3'h0;
    port1_pin_in = 8'h5C;
    ext_p0 = 8'hC3;
    reset_check();
    foreach (rows[i]) begin
      acc(rows[i], rd, rf);
      `CHK("refused", rows[i].exp_ref, rf)
      if (!rows[i].w) `CHK("read data", rows[i].exp_rd, rd)
    end
    $display("Test register rows done");
    `CHK("pullup on", 1'b1, port_zero_pullup_enable_out)
    `CHK("p0 open drain", 16'h3D00, {port0_oe_n_out, port0_pin_out})
    xm(1'b1, 3'h0, 8'h6B);
    xm(1'b1, 3'h7, 8'h94);
    xm(1'b0, 3'h3, 8'h00);
    @(negedge clk_in);
    `CHK("bus released", 8'h3D, port0_oe_n_out)
    gap(1'b0, g);
    `CHK("machine cycle", 4, g)
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_in);
      timer_slow_in <= s[0];
      gap(1'b1, g);
      gap(1'b1, g);
      `CHK("timer gap", s ? 12 : 4, g)
    end
    @(posedge clk_in);
    port1_pin_in <= 8'hE1;
    repeat (4) @(negedge clk_in);
    `CHK("adc pins", 8'hE1, adc_pins_out)
    $display("Test timing and port one done");
    reset_check();
    final_report();
  end
endmodule
